// [rtl/limit_ration_pkg.sv]
// constants for the port limit and charge budget register slice
// assumes a byte-wide register port decoded by the serial front end
`default_nettype none
package limit_ration_pkg;
  // register offsets
  localparam logic [7:0] CHARGE_BUDGET_CONFIG_OFS  = 8'h22;
  localparam logic [7:0] PORT1_LIMIT_BEHAVIOUR_OFS = 8'h23;
  localparam logic [7:0] PORT2_LIMIT_BEHAVIOUR_OFS = 8'h24;
  localparam logic [7:0] PRODUCT_IDENTITY_OFS      = 8'hfd;
  localparam logic [7:0] MAKER_IDENTITY_OFS        = 8'hfe;
  localparam logic [7:0] SILICON_VERSION_OFS       = 8'hff;
  // field positions in charge_budget_config
  localparam int PORT1_BUDGET_ENABLE_BIT = 3;
  localparam int PORT1_BUDGET_CLEAR_BIT  = 2;
  // field positions in the limit behaviour registers
  localparam int FLOOR_VOLTAGE_LSB = 6;
  localparam int FLOOR_CURRENT_LSB = 2;
  localparam int UNUSED_LIMIT_BIT  = 5;
  // reset values and limit write mask
  localparam logic [7:0] CHARGE_BUDGET_CONFIG_RST = 8'h00;
  localparam logic [7:0] LIMIT_BEHAVIOUR_RST      = 8'h96;
  localparam logic [7:0] LIMIT_WRITE_MASK         = 8'hdf;
  // floor voltages in millivolts, floor currents in milliamps, highest defined current code
  localparam logic [11:0] FLOOR_MV_0 = 12'd1500;
  localparam logic [11:0] FLOOR_MV_1 = 12'd1750;
  localparam logic [11:0] FLOOR_MV_2 = 12'd2000;
  localparam logic [11:0] FLOOR_MV_3 = 12'd2250;
  localparam logic [11:0] FLOOR_MA_0 = 12'd100;
  localparam logic [11:0] FLOOR_MA_1 = 12'd530;
  localparam logic [11:0] FLOOR_MA_2 = 12'd960;
  localparam logic [11:0] FLOOR_MA_3 = 12'd1280;
  localparam logic [11:0] FLOOR_MA_4 = 12'd1600;
  localparam logic [11:0] FLOOR_MA_5 = 12'd2130;
  localparam logic [2:0]  FLOOR_CURRENT_MAX_CODE = 3'h5;
  // identity codes, values arbitrary
  localparam logic [7:0] FAMILY_CODE_DEF          = 8'h5a;
  localparam logic [7:0] MAKER_CODE_DEF           = 8'h3c;
  localparam logic [7:0] SILICON_VERSION_CODE_DEF = 8'h01;
  // charge count width
  localparam int CHARGE_WIDTH = 16;
endpackage
`default_nettype wire

// [rtl/port_limit_ration_regs.sv]
// register slice: port 1 charge budget control, per-port limit
// behaviour, identity registers
// assumes the serial front end gives a one-cycle write or read strobe
// with an 8-bit address and data, synchronous to core_clk
// assumes sleepEnter comes from the power controller, synchronous to core_clk
// assumes port1ChargeTick marks one unit of accumulated port 1 charge
//
// Overview of operation
// - budget disable clears port 1 count, stops counting, drops response and flag
// - setting budget clear zeroes count, clears flag, releases alert if idle
// - port 1 budgeting only runs while the clear bit is zero
// - both limit behaviour registers return to reset value on sleep entry
// - port 1 floor voltage code selects 1.50, 1.75, 2.0 or 2.25 V
// - port 1 floor current codes 0 to 5 select 100 to 2130 mA
// - port 2 limit behaviour register uses the same layout as port 1
// - product identity at FDh reads a fixed family code
// - maker identity at FEh reads a fixed maker code
// - silicon version at FFh reads a fixed revision code
`default_nettype none
module port_limit_ration_regs
  import limit_ration_pkg::*;
#(
  parameter logic [7:0] FAMILY_CODE          = limit_ration_pkg::FAMILY_CODE_DEF,
  parameter logic [7:0] MAKER_CODE           = limit_ration_pkg::MAKER_CODE_DEF,
  parameter logic [7:0] SILICON_VERSION_CODE = limit_ration_pkg::SILICON_VERSION_CODE_DEF,
  parameter logic [limit_ration_pkg::CHARGE_WIDTH-1:0] BUDGET_THRESHOLD = 16'hffff
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  output logic      [7:0]  regRdata,
  output logic             regHit,
  input  wire logic        sleepEnter,
  input  wire logic        port1ChargeTick,
  input  wire logic        port1OtherAlert,
  output logic [limit_ration_pkg::CHARGE_WIDTH-1:0] port1ChargeCount,
  output logic             port1_budget_hit_flag,
  output logic             port1BudgetResponse,
  output logic             port1Alert_n,
  output logic [1:0]       port1_floor_voltage_sel,
  output logic [2:0]       port1_floor_current_sel,
  output logic [1:0]       port2_floor_voltage_sel,
  output logic [2:0]       port2_floor_current_sel,
  output logic [11:0]      port1FloorMv,
  output logic [11:0]      port1FloorMa,
  output logic [11:0]      port2FloorMv,
  output logic [11:0]      port2FloorMa,
  output logic             port1CurrentReserved,
  output logic             port2CurrentReserved
);
  import limit_ration_pkg::*;

  // floor voltage decode, shared by both ports
  function automatic logic [11:0] floorMv(input logic [1:0] code);
    logic [11:0] v;
    v = FLOOR_MV_0;
    unique case (code)
      2'h0: v = FLOOR_MV_0;
      2'h1: v = FLOOR_MV_1;
      2'h2: v = FLOOR_MV_2;
      2'h3: v = FLOOR_MV_3;
    endcase
    return v;
  endfunction

  // floor current decode; reserved codes give zero
  function automatic logic [11:0] floorMa(input logic [2:0] code);
    logic [11:0] v;
    v = 12'h000;
    case (code)
      3'h0:    v = FLOOR_MA_0;
      3'h1:    v = FLOOR_MA_1;
      3'h2:    v = FLOOR_MA_2;
      3'h3:    v = FLOOR_MA_3;
      3'h4:    v = FLOOR_MA_4;
      3'h5:    v = FLOOR_MA_5;
      default: v = 12'h000;
    endcase
    return v;
  endfunction

  logic [7:0] budgetCfg_q;
  logic [7:0] limit1_q;
  logic [7:0] limit2_q;
  logic [CHARGE_WIDTH-1:0] count_q;
  logic [CHARGE_WIDTH-1:0] count_d;
  logic       hit_q;
  logic       hit_d;

  // address decode
  wire selCfg    = (regAddr == CHARGE_BUDGET_CONFIG_OFS);
  wire selLimit1 = (regAddr == PORT1_LIMIT_BEHAVIOUR_OFS);
  wire selLimit2 = (regAddr == PORT2_LIMIT_BEHAVIOUR_OFS);
  wire selFamily  = (regAddr == PRODUCT_IDENTITY_OFS);
  wire selMaker   = (regAddr == MAKER_IDENTITY_OFS);
  wire selVersion = (regAddr == SILICON_VERSION_OFS);
  wire wrCfg     = regWrite & selCfg;
  wire wrLimit1  = regWrite & selLimit1;
  wire wrLimit2  = regWrite & selLimit2;

  // budget control bits as they stand
  // clear is a level: counting stays held until the host drops it
  wire budgetEnable = budgetCfg_q[PORT1_BUDGET_ENABLE_BIT];
  wire budgetClear  = budgetCfg_q[PORT1_BUDGET_CLEAR_BIT];
  wire budgetRun    = budgetEnable & ~budgetClear;
  wire budgetKill   = ~budgetEnable | budgetClear;

  // configuration register, fully writable
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      budgetCfg_q <= CHARGE_BUDGET_CONFIG_RST;
    end else if (wrCfg) begin
      budgetCfg_q <= regWdata;
    end
  end

  // limit behaviour registers: sleep restores defaults, bit 5 never stored
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      limit1_q <= LIMIT_BEHAVIOUR_RST;
      limit2_q <= LIMIT_BEHAVIOUR_RST;
    end else if (sleepEnter) begin
      limit1_q <= LIMIT_BEHAVIOUR_RST;
      limit2_q <= LIMIT_BEHAVIOUR_RST;
    end else begin
      if (wrLimit1) begin
        limit1_q <= regWdata & LIMIT_WRITE_MASK;
      end
      if (wrLimit2) begin
        limit2_q <= regWdata & LIMIT_WRITE_MASK;
      end
    end
  end

  // charge count and threshold flag next values
  // count saturates at the threshold; a held clear or disable beats a hit
  assign count_d = budgetKill ? '0 :
                   (budgetRun && port1ChargeTick && count_q != BUDGET_THRESHOLD)
                   ? count_q + 1'b1 : count_q;
  assign hit_d   = budgetKill ? 1'b0 : (hit_q | (count_q == BUDGET_THRESHOLD));

  // charge accumulation state
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_q <= '0;
      hit_q   <= 1'b0;
    end else begin
      count_q <= count_d;
      hit_q   <= hit_d;
    end
  end

  // field views and decoded floors
  assign port1_floor_voltage_sel = limit1_q[FLOOR_VOLTAGE_LSB +: 2];
  assign port1_floor_current_sel = limit1_q[FLOOR_CURRENT_LSB +: 3];
  assign port2_floor_voltage_sel = limit2_q[FLOOR_VOLTAGE_LSB +: 2];
  assign port2_floor_current_sel = limit2_q[FLOOR_CURRENT_LSB +: 3];
  assign port1FloorMv = floorMv(port1_floor_voltage_sel);
  assign port1FloorMa = floorMa(port1_floor_current_sel);
  assign port2FloorMv = floorMv(port2_floor_voltage_sel);
  assign port2FloorMa = floorMa(port2_floor_current_sel);
  assign port1CurrentReserved = port1_floor_current_sel > FLOOR_CURRENT_MAX_CODE;
  assign port2CurrentReserved = port2_floor_current_sel > FLOOR_CURRENT_MAX_CODE;

  // status outputs
  assign port1ChargeCount      = count_q;
  assign port1_budget_hit_flag = hit_q;
  assign port1BudgetResponse   = hit_q;
  assign port1Alert_n          = ~(hit_q | port1OtherAlert);

  // read mux; unmapped addresses read zero with no hit
  // identity codes are parameters so a derivative can change them
  assign regHit   = regRead & (selCfg | selLimit1 | selLimit2 | selFamily | selMaker | selVersion);
  assign regRdata = selCfg     ? budgetCfg_q :
                    selLimit1  ? limit1_q :
                    selLimit2  ? limit2_q :
                    selFamily  ? FAMILY_CODE :
                    selMaker   ? MAKER_CODE :
                    selVersion ? SILICON_VERSION_CODE :
                    8'h00;

  // assertions
  disable_count_a: assert property (@(posedge core_clk) disable iff (reset)
    !budgetEnable |=> (count_q == '0 && !hit_q))
    else $error("count or flag kept while budget disabled");
  clear_flag_a: assert property (@(posedge core_clk) disable iff (reset)
    budgetClear |=> (!hit_q && count_q == '0))
    else $error("budget clear did not zero state");
  alert_release_a: assert property (@(posedge core_clk) disable iff (reset)
    (!hit_q && !port1OtherAlert) |-> port1Alert_n)
    else $error("alert held with no cause");
  run_gate_a: assert property (@(posedge core_clk) disable iff (reset)
    (count_q != $past(count_q) && count_q != '0) |-> $past(budgetRun && port1ChargeTick))
    else $error("count moved without running budget");
  sleep_lose_a: assert property (@(posedge core_clk) disable iff (reset)
    sleepEnter |=> (limit1_q == LIMIT_BEHAVIOUR_RST && limit2_q == LIMIT_BEHAVIOUR_RST))
    else $error("limit registers kept across sleep");
  volt_map_a: assert property (@(posedge core_clk) disable iff (reset)
    port1_floor_voltage_sel == 2'h3 |-> port1FloorMv == FLOOR_MV_3)
    else $error("port 1 floor voltage decode wrong");
  curr_map_a: assert property (@(posedge core_clk) disable iff (reset)
    port1_floor_current_sel == 3'h5 |-> port1FloorMa == FLOOR_MA_5)
    else $error("port 1 floor current decode wrong");
  port2_write_a: assert property (@(posedge core_clk) disable iff (reset)
    (wrLimit2 && !sleepEnter) |=> limit2_q == ($past(regWdata) & LIMIT_WRITE_MASK))
    else $error("port 2 limit write not stored");
  family_read_a: assert property (@(posedge core_clk) disable iff (reset)
    (regRead && selFamily) |-> (regHit && regRdata == FAMILY_CODE))
    else $error("family code read wrong");
  maker_read_a: assert property (@(posedge core_clk) disable iff (reset)
    (regRead && selMaker) |-> regRdata == MAKER_CODE)
    else $error("maker code read wrong");
  version_read_a: assert property (@(posedge core_clk) disable iff (reset)
    (regRead && selVersion) |-> regRdata == SILICON_VERSION_CODE)
    else $error("revision code read wrong");
  bit5_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    !limit1_q[UNUSED_LIMIT_BIT] && !limit2_q[UNUSED_LIMIT_BIT])
    else $error("unused limit bit set");
  reserved_a: assert property (@(posedge core_clk) disable iff (reset)
    port1CurrentReserved |-> port1FloorMa == 12'h000)
    else $error("reserved current code decoded");

  // remaining floor codes on port 1
  volt_code0_a: assert property (@(posedge core_clk) disable iff (reset)
    port1_floor_voltage_sel == 2'h0 |-> port1FloorMv == FLOOR_MV_0)
    else $error("port 1 floor voltage code 0 wrong");
  volt_code1_a: assert property (@(posedge core_clk) disable iff (reset)
    port1_floor_voltage_sel == 2'h1 |-> port1FloorMv == FLOOR_MV_1)
    else $error("port 1 floor voltage code 1 wrong");
  volt_code2_a: assert property (@(posedge core_clk) disable iff (reset)
    port1_floor_voltage_sel == 2'h2 |-> port1FloorMv == FLOOR_MV_2)
    else $error("port 1 floor voltage code 2 wrong");
  curr_code0_a: assert property (@(posedge core_clk) disable iff (reset)
    port1_floor_current_sel == 3'h0 |-> port1FloorMa == FLOOR_MA_0)
    else $error("port 1 floor current code 0 wrong");
  curr_code1_a: assert property (@(posedge core_clk) disable iff (reset)
    port1_floor_current_sel == 3'h1 |-> port1FloorMa == FLOOR_MA_1)
    else $error("port 1 floor current code 1 wrong");
  curr_code2_a: assert property (@(posedge core_clk) disable iff (reset)
    port1_floor_current_sel == 3'h2 |-> port1FloorMa == FLOOR_MA_2)
    else $error("port 1 floor current code 2 wrong");
  curr_code3_a: assert property (@(posedge core_clk) disable iff (reset)
    port1_floor_current_sel == 3'h3 |-> port1FloorMa == FLOOR_MA_3)
    else $error("port 1 floor current code 3 wrong");
  curr_code4_a: assert property (@(posedge core_clk) disable iff (reset)
    port1_floor_current_sel == 3'h4 |-> port1FloorMa == FLOOR_MA_4)
    else $error("port 1 floor current code 4 wrong");

  // port 2 decodes the same table from its own register
  port2_volt0_a: assert property (@(posedge core_clk) disable iff (reset)
    port2_floor_voltage_sel == 2'h0 |-> port2FloorMv == FLOOR_MV_0)
    else $error("port 2 floor voltage code 0 wrong");
  port2_volt1_a: assert property (@(posedge core_clk) disable iff (reset)
    port2_floor_voltage_sel == 2'h1 |-> port2FloorMv == FLOOR_MV_1)
    else $error("port 2 floor voltage code 1 wrong");
  port2_volt2_a: assert property (@(posedge core_clk) disable iff (reset)
    port2_floor_voltage_sel == 2'h2 |-> port2FloorMv == FLOOR_MV_2)
    else $error("port 2 floor voltage code 2 wrong");
  port2_volt3_a: assert property (@(posedge core_clk) disable iff (reset)
    port2_floor_voltage_sel == 2'h3 |-> port2FloorMv == FLOOR_MV_3)
    else $error("port 2 floor voltage code 3 wrong");
  port2_curr0_a: assert property (@(posedge core_clk) disable iff (reset)
    port2_floor_current_sel == 3'h0 |-> port2FloorMa == FLOOR_MA_0)
    else $error("port 2 floor current code 0 wrong");
  port2_curr5_a: assert property (@(posedge core_clk) disable iff (reset)
    port2_floor_current_sel == 3'h5 |-> port2FloorMa == FLOOR_MA_5)
    else $error("port 2 floor current code 5 wrong");
  port2_reserved_a: assert property (@(posedge core_clk) disable iff (reset)
    port2CurrentReserved |-> port2FloorMa == 12'h000)
    else $error("port 2 reserved current code decoded");

  // register writes, counting and alert
  port1_write_a: assert property (@(posedge core_clk) disable iff (reset)
    (wrLimit1 && !sleepEnter) |=> limit1_q == ($past(regWdata) & LIMIT_WRITE_MASK))
    else $error("port 1 limit write not stored");
  cfg_write_a: assert property (@(posedge core_clk) disable iff (reset)
    wrCfg |=> budgetCfg_q == $past(regWdata))
    else $error("budget configuration write not stored");
  count_cap_a: assert property (@(posedge core_clk) disable iff (reset)
    count_q <= BUDGET_THRESHOLD)
    else $error("charge count passed the threshold");
  flag_set_a: assert property (@(posedge core_clk) disable iff (reset)
    (budgetRun && count_q == BUDGET_THRESHOLD) |=> hit_q)
    else $error("threshold reached without flag");
  response_drop_a: assert property (@(posedge core_clk) disable iff (reset)
    !budgetEnable |=> !port1BudgetResponse)
    else $error("response kept while budget disabled");
  alert_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    hit_q |-> !port1Alert_n)
    else $error("alert released while flag set");

  // main scenarios
  hit_c:    cover property (@(posedge core_clk) disable iff (reset) $rose(hit_q));
  clear_c:  cover property (@(posedge core_clk) disable iff (reset) hit_q ##1 budgetClear);
  sleep_c:  cover property (@(posedge core_clk) disable iff (reset) wrLimit1 ##[1:5] sleepEnter);
  idread_c: cover property (@(posedge core_clk) disable iff (reset) regRead && selVersion);
  off_c:    cover property (@(posedge core_clk) disable iff (reset) hit_q ##1 !budgetEnable);
endmodule // port_limit_ration_regs
`default_nettype wire

// [tb/host_model.sv]
// host controller model: single-byte register writes and reads
// assumes strobes launch at the falling edge of core_clk
`default_nettype none
module host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] regRdata,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 8'h00;
    regWdata = 8'h00;
  end
  // one-cycle write strobe, data inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regWrite = 1'b1;
    regAddr  = a;
    regWdata = d;
    @(negedge core_clk);
    regWrite = 1'b0;
    regWdata = ~d;
  endtask
  // one-cycle read strobe, data taken at the rising edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    regRead = 1'b1;
    regAddr = a;
    @(posedge core_clk);
    d = regRdata;
    @(negedge core_clk);
    regRead = 1'b0;
  endtask
  // update fields but write the low two bits back unchanged
  task automatic rmw(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] old;
    rd(a, old);
    wr(a, {d[7:2], old[1:0]});
  endtask
endmodule // host_model
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the limit and charge budget register slice
// assumes host_model drives the register strobes
`default_nettype none
module tb;
  import limit_ration_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, reset, sleepEnter, port1ChargeTick, port1OtherAlert;
  logic        regWrite, regRead, regHit, port1_budget_hit_flag, port1BudgetResponse;
  logic        port1Alert_n, port1CurrentReserved, port2CurrentReserved;
  logic        lastHit;
  logic [7:0]  regAddr, regWdata, regRdata, rv;
  logic [15:0] port1ChargeCount;
  logic [1:0]  port1_floor_voltage_sel, port2_floor_voltage_sel;
  logic [2:0]  port1_floor_current_sel, port2_floor_current_sel;
  logic [11:0] port1FloorMv, port1FloorMa, port2FloorMv, port2FloorMa;
  logic [11:0] mv [4] = '{12'd1500, 12'd1750, 12'd2000, 12'd2250};
  logic [11:0] ma [8] = '{12'd100, 12'd530, 12'd960, 12'd1280, 12'd1600, 12'd2130, 12'd0, 12'd0};
  logic [7:0]  ids [3] = '{8'ha7, 8'h4b, 8'h2e}; // identity values arbitrary
  int          n_fail = 0;
  int          compares = 0;
  // design and host
  port_limit_ration_regs #(
    .FAMILY_CODE(8'ha7), .MAKER_CODE(8'h4b), .SILICON_VERSION_CODE(8'h2e),
    .BUDGET_THRESHOLD(16'h0004)
  ) uut (
    .core_clk, .reset, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .regHit,
    .sleepEnter, .port1ChargeTick, .port1OtherAlert, .port1ChargeCount,
    .port1_budget_hit_flag, .port1BudgetResponse, .port1Alert_n,
    .port1_floor_voltage_sel, .port1_floor_current_sel, .port2_floor_voltage_sel,
    .port2_floor_current_sel, .port1FloorMv, .port1FloorMa, .port2FloorMv, .port2FloorMa,
    .port1CurrentReserved, .port2CurrentReserved
  );
  host_model host (.core_clk, .regRdata, .regWrite, .regRead, .regAddr, .regWdata);
  // hit seen with each read strobe
  always @(posedge core_clk) begin
    if (regRead) begin
      lastHit <= regHit;
    end
  end
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and stop
  task automatic end_sim;
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // charge ticks held high for n rising edges
  task automatic pulse(input int n);
    @(negedge core_clk);
    port1ChargeTick = 1'b1;
    repeat (n) @(negedge core_clk);
    port1ChargeTick = 1'b0;
  endtask
  // hang guard
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
  // main sequence
  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    sleepEnter = 1'b0;
    port1ChargeTick = 1'b0;
    port1OtherAlert = 1'b0;
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    host.rd(8'h22, rv);
    chk(16'(rv), 16'h0000);
    // identity registers ignore writes
    for (int i = 0; i < 3; i++) begin
      host.wr(8'hfd + 8'(i), 8'h00);
      host.rd(8'hfd + 8'(i), rv);
      chk(16'(rv), 16'(ids[i]));
      chk(16'(lastHit), 16'h0001);
    end
    // unmapped place reads zero
    host.wr(8'h30, 8'hff);
    host.rd(8'h30, rv);
    chk(16'(rv), 16'h0000);
    chk(16'(lastHit), 16'h0000);
    // every floor code on both ports, bit 5 written high
    for (int p = 0; p < 2; p++) begin
      for (int v = 0; v < 4; v++) begin
        for (int c = 0; c < 8; c++) begin
          host.rmw(8'h23 + 8'(p), {2'(v), 1'b1, 3'(c), 2'b01});
          host.rd(8'h23 + 8'(p), rv);
          chk(16'(rv), 16'({2'(v), 1'b0, 3'(c), 2'b10}));
          chk(16'(p ? port2FloorMv : port1FloorMv), 16'(mv[v]));
          chk(16'(p ? port2FloorMa : port1FloorMa), 16'(ma[c]));
          chk(16'(p ? port2CurrentReserved : port1CurrentReserved), 16'(c > 5));
          chk(16'(p ? port2_floor_voltage_sel : port1_floor_voltage_sel), 16'(v));
          chk(16'(p ? port2_floor_current_sel : port1_floor_current_sel), 16'(c));
        end
      end
    end
    // sleep entry drops the limit settings
    @(negedge core_clk);
    sleepEnter = 1'b1;
    @(negedge core_clk);
    sleepEnter = 1'b0;
    for (int p = 0; p < 2; p++) begin
      host.rd(8'h23 + 8'(p), rv);
      chk(16'(rv), 16'h0096);
    end
    // count up to the threshold
    host.wr(8'h22, 8'h08);
    pulse(6);
    chk(port1ChargeCount, 16'h0004);
    chk(16'({port1_budget_hit_flag, port1BudgetResponse, port1Alert_n}), 16'h0006);
    // clear held while another alert stands
    port1OtherAlert = 1'b1;
    host.wr(8'h22, 8'h0c);
    pulse(3);
    chk(port1ChargeCount, 16'h0000);
    chk(16'({port1_budget_hit_flag, port1BudgetResponse, port1Alert_n}), 16'h0000);
    port1OtherAlert = 1'b0;
    @(negedge core_clk);
    chk(16'(port1Alert_n), 16'h0001);
    // refill, then disable
    host.wr(8'h22, 8'h08);
    pulse(6);
    chk(16'(port1_budget_hit_flag), 16'h0001);
    host.wr(8'h22, 8'h00);
    pulse(2);
    chk(port1ChargeCount, 16'h0000);
    chk(16'({port1_budget_hit_flag, port1BudgetResponse, port1Alert_n}), 16'h0001);
    // mid-run reset restores defaults
    host.rmw(8'h23, 8'h40);
    host.wr(8'h22, 8'h08);
    @(negedge core_clk);
    reset = 1'b1;
    @(negedge core_clk);
    reset = 1'b0;
    host.rd(8'h22, rv);
    chk(16'(rv), 16'h0000);
    host.rd(8'h23, rv);
    chk(16'(rv), 16'h0096);
    end_sim();
  end
endmodule // tb
`default_nettype wire
